// >>> shared/hpdr_cfg.svh
// constants for the hot-plug detect receiver: register offsets, field positions,
// reset values and the timing base.
// assumes a 25 MHz core clock and a byte-wide register port.
`ifndef HPDR_CFG_SVH
`define HPDR_CFG_SVH

// ==========================================================================
// register offsets (byte addresses on the register port)
`define HPDR_ADDR_W 12
`define HPDR_ADDR_CTL 12'hc00
`define HPDR_ADDR_STS 12'hc01
`define HPDR_ADDR_IEN 12'hc02
`define HPDR_ADDR_QUEUE 12'hc03
`define HPDR_ADDR_MIN 12'hc04
`define HPDR_ADDR_MAX 12'hc05
`define HPDR_ADDR_HI_LO 12'hc06
`define HPDR_ADDR_HI_HI 12'hc07
`define HPDR_ADDR_LO_LO 12'hc08
`define HPDR_ADDR_LO_HI 12'hc09

// ==========================================================================
// control register fields
`define HPDR_CTL_EN 0
`define HPDR_CTL_DIR 1
`define HPDR_CTL_OUTV 3
`define HPDR_CTL_STATE 7
// direction encoding
`define HPDR_DIR_IN 1'h0

// ==========================================================================
// status / enable fields
`define HPDR_ST_PULSE 0
`define HPDR_ST_HIGH 1
`define HPDR_ST_LOW 2
`define HPDR_ST_QNE 3
// queue entry codes, two bits per entry, entry 0 oldest
`define HPDR_EV_NONE 2'h0
`define HPDR_EV_HIGH 2'h1
`define HPDR_EV_LOW 2'h2
`define HPDR_EV_PULSE 2'h3
`define HPDR_Q_DEPTH 3'h4

// ==========================================================================
// reset values
`define HPDR_RST_BYTE 8'h00
`define HPDR_RST_WORD 16'h0000

// ==========================================================================
// timing base: every width register counts in ticks of this length
`define HPDR_CLK_KHZ 25000
`define HPDR_TICK_US 10
`define HPDR_TICK_CYC ((`HPDR_TICK_US * `HPDR_CLK_KHZ) / 1000)

`endif

// >>> shared/hpdr_pkg.sv
// types shared by the hot-plug detect receiver.
// assumes hpdr_cfg.svh is on the include path.
`default_nettype none
package hpdr_pkg;

  // ========================================================================
  // detector states
  typedef enum logic [1:0] {
    HPDR_OFF = 2'b00,
    HPDR_LOW = 2'b01,
    HPDR_HIGH = 2'b10,
    HPDR_LOW_CNT = 2'b11
  } hpdr_det_type;

  // ========================================================================
  // register port request
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } hpdr_bus_type;

  // hot-plug pin drive
  typedef struct packed {
    logic out;
    logic oe;
  } hpdr_pin_type;

  // ========================================================================
  // complete state of the receiver
  typedef struct packed {
    logic sync1;
    logic sync2;
    hpdr_det_type det;
    logic [7:0] presc;
    logic [15:0] cnt;
    logic en;
    logic dir;
    logic out_val;
    logic [3:0] ien;
    logic [2:0] sts;
    logic [7:0] queue;
    logic [2:0] q_cnt;
    logic [7:0] min_w;
    logic [7:0] max_w;
    logic [15:0] hi_det;
    logic [15:0] lo_det;
    logic [7:0] rdata;
    logic irq;
  } hpdr_state_type;

endpackage

`default_nettype wire

// >>> logic/hpdr_receiver.sv
// hot-plug detect receiver: pin sampling, debounce, short-pulse classification,
// four-entry event queue and status flags, behind a byte-wide register port.
// assumes one 25 MHz clock, synchronous reset, and a register master that
// never issues read and write strobes together.
`timescale 1ns/1ps
`include "hpdr_cfg.svh"
`default_nettype none

module hpdr_receiver (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire hpdr_pkg::hpdr_bus_type bus_in,
  output logic [7:0] rdata_out,
  input wire logic hot_plug_pin_in,
  output hpdr_pkg::hpdr_pin_type hot_plug_pin_out,
  output logic hot_plug_summary_irq_out
);

  // ========================================================================
  // helpers

  // a programmed width is reached once the elapsed tick count meets it
  // the counter saturates, so a line stuck low never wraps back under a limit
  function automatic logic width_reached(input logic [15:0] elapsed, input logic [15:0] limit);
    width_reached = (elapsed >= limit);
  endfunction

  // append one event code at the tail; a full queue keeps what it holds
  // code none pushes nothing, so callers may pass the event code every cycle
  function automatic logic [10:0] queue_push(input logic [7:0] q, input logic [2:0] n,
                                             input logic [1:0] code);
    logic [7:0] qn;
    logic [2:0] nn;
    qn = q;
    nn = n;
    if (code != `HPDR_EV_NONE && n < `HPDR_Q_DEPTH) begin
      qn[n[1:0]*2 +: 2] = code;
      nn = n + 3'h1;
    end
    queue_push = {qn, nn};
  endfunction

  // ========================================================================
  // state

  hpdr_pkg::hpdr_state_type s_r;
  hpdr_pkg::hpdr_state_type s_nxt;
  logic active;
  logic line;
  logic tick;
  logic logic_high;
  logic pin_state;
  // event code raised by the detector this cycle, none most of the time
  logic [1:0] ev;
  // status bits software asked to clear this cycle
  logic [2:0] w1c;
  logic q_clear;

  // receiver active only as an enabled input
  assign active = s_r.en & (s_r.dir == `HPDR_DIR_IN);
  // line is the second synchroniser stage only
  assign line = s_r.sync2;
  // one tick per prescaler wrap: widths resolve to whole ticks and round down
  assign tick = (s_r.presc == 8'(`HPDR_TICK_CYC - 1));
  // logical state: high in steady high and while a low is still being timed
  assign logic_high = (s_r.det == hpdr_pkg::HPDR_HIGH) || (s_r.det == hpdr_pkg::HPDR_LOW_CNT);
  // reported pin state follows the driven value when the pin is an output
  assign pin_state = s_r.en & (s_r.dir ? s_r.out_val : logic_high);

  // ========================================================================
  // next-state logic
  always_comb begin
    s_nxt = s_r;
    ev = `HPDR_EV_NONE;
    w1c = 3'h0;
    q_clear = 1'b0;

    // two-flop synchroniser on the pin
    // the raw pin may move near the edge; only the second stage feeds logic
    s_nxt.sync1 = hot_plug_pin_in;
    s_nxt.sync2 = s_r.sync1;

    // register writes
    if (bus_in.wr) begin
      case (bus_in.addr)
        `HPDR_ADDR_CTL: begin
          // direction is not guarded here; software keeps it fixed while enabled
          s_nxt.en = bus_in.wdata[`HPDR_CTL_EN];
          s_nxt.dir = bus_in.wdata[`HPDR_CTL_DIR];
          s_nxt.out_val = bus_in.wdata[`HPDR_CTL_OUTV];
        end
        `HPDR_ADDR_STS: begin
          w1c = bus_in.wdata[2:0];
        end
        `HPDR_ADDR_IEN: begin
          s_nxt.ien = bus_in.wdata[3:0];
        end
        `HPDR_ADDR_QUEUE: begin
          // any write empties the queue: software has consumed what it read
          q_clear = 1'b1;
        end
        `HPDR_ADDR_MIN: begin
          s_nxt.min_w = bus_in.wdata;
        end
        `HPDR_ADDR_MAX: begin
          s_nxt.max_w = bus_in.wdata;
        end
        `HPDR_ADDR_HI_LO: begin
          s_nxt.hi_det[7:0] = bus_in.wdata;
        end
        `HPDR_ADDR_HI_HI: begin
          s_nxt.hi_det[15:8] = bus_in.wdata;
        end
        `HPDR_ADDR_LO_LO: begin
          s_nxt.lo_det[7:0] = bus_in.wdata;
        end
        `HPDR_ADDR_LO_HI: begin
          s_nxt.lo_det[15:8] = bus_in.wdata;
        end
        default: begin
          // unmapped writes are ignored
        end
      endcase
    end

    // tick prescaler and saturating width counter
    s_nxt.presc = tick ? 8'h00 : s_r.presc + 8'h01;
    if (tick && s_r.cnt != 16'hffff) begin
      s_nxt.cnt = s_r.cnt + 16'h0001;
    end

    // detector
    case (s_r.det)
      hpdr_pkg::HPDR_OFF: begin
        // start from logical low so a present display is debounced first
        s_nxt.det = hpdr_pkg::HPDR_LOW;
        s_nxt.cnt = `HPDR_RST_WORD;
        s_nxt.presc = 8'h00;
      end
      hpdr_pkg::HPDR_LOW: begin
        if (!line) begin
          s_nxt.cnt = `HPDR_RST_WORD;
          s_nxt.presc = 8'h00;
        end else if (width_reached(s_r.cnt, s_r.hi_det)) begin
          s_nxt.det = hpdr_pkg::HPDR_HIGH;
          ev = `HPDR_EV_HIGH;
        end
      end
      hpdr_pkg::HPDR_HIGH: begin
        if (!line) begin
          s_nxt.det = hpdr_pkg::HPDR_LOW_CNT;
          s_nxt.cnt = `HPDR_RST_WORD;
          s_nxt.presc = 8'h00;
        end
      end
      hpdr_pkg::HPDR_LOW_CNT: begin
        if (line) begin
          // back high: a pulse inside the window, otherwise a glitch
          // a rise at exactly the maximum width still counts as a pulse
          s_nxt.det = hpdr_pkg::HPDR_HIGH;
          if (width_reached(s_r.cnt, {8'h00, s_r.min_w}) && !width_reached(s_r.cnt, {8'h00, s_r.max_w} + 16'h0001)) begin
            ev = `HPDR_EV_PULSE;
          end
        end else if (width_reached(s_r.cnt, s_r.lo_det)) begin
          // only the long low-detect time ends the logical high
          s_nxt.det = hpdr_pkg::HPDR_LOW;
          s_nxt.cnt = `HPDR_RST_WORD;
          s_nxt.presc = 8'h00;
          ev = `HPDR_EV_LOW;
        end
      end
      default: begin
        s_nxt.det = hpdr_pkg::HPDR_OFF;
      end
    endcase

    // status flags: write-one-to-clear, a new event wins over the clear
    s_nxt.sts = s_r.sts & ~w1c;
    if (ev == `HPDR_EV_PULSE) begin
      s_nxt.sts[`HPDR_ST_PULSE] = 1'b1;
    end
    if (ev == `HPDR_EV_HIGH) begin
      s_nxt.sts[`HPDR_ST_HIGH] = 1'b1;
    end
    if (ev == `HPDR_EV_LOW) begin
      s_nxt.sts[`HPDR_ST_LOW] = 1'b1;
    end

    // queue: clear first so an event in the clearing cycle is kept
    if (q_clear) begin
      s_nxt.queue = `HPDR_RST_BYTE;
      s_nxt.q_cnt = 3'h0;
    end
    {s_nxt.queue, s_nxt.q_cnt} = queue_push(s_nxt.queue, s_nxt.q_cnt, ev);

    // not monitoring: detector idle and queue empty
    // status survives a switch to output; only clearing enable zeroes it
    if (!active) begin
      s_nxt.det = hpdr_pkg::HPDR_OFF;
      s_nxt.queue = `HPDR_RST_BYTE;
      s_nxt.q_cnt = 3'h0;
    end
    if (!s_r.en) begin
      s_nxt.sts = 3'h0;
    end

    // read data, valid in the cycle after the strobe only
    // reserved bits and unmapped addresses read zero
    s_nxt.rdata = `HPDR_RST_BYTE;
    if (bus_in.rd) begin
      case (bus_in.addr)
        `HPDR_ADDR_CTL: begin
          s_nxt.rdata[`HPDR_CTL_STATE] = pin_state;
          // output value reads zero unless the pin is an output
          s_nxt.rdata[`HPDR_CTL_OUTV] = s_r.dir & s_r.out_val;
          s_nxt.rdata[`HPDR_CTL_DIR] = s_r.dir;
          s_nxt.rdata[`HPDR_CTL_EN] = s_r.en;
        end
        `HPDR_ADDR_STS: begin
          s_nxt.rdata = {4'h0, (s_r.q_cnt != 3'h0), s_r.sts};
        end
        `HPDR_ADDR_IEN: begin
          s_nxt.rdata = {4'h0, s_r.ien};
        end
        `HPDR_ADDR_QUEUE: begin
          s_nxt.rdata = s_r.queue;
        end
        `HPDR_ADDR_MIN: begin
          s_nxt.rdata = s_r.min_w;
        end
        `HPDR_ADDR_MAX: begin
          s_nxt.rdata = s_r.max_w;
        end
        `HPDR_ADDR_HI_LO: begin
          s_nxt.rdata = s_r.hi_det[7:0];
        end
        `HPDR_ADDR_HI_HI: begin
          s_nxt.rdata = s_r.hi_det[15:8];
        end
        `HPDR_ADDR_LO_LO: begin
          s_nxt.rdata = s_r.lo_det[7:0];
        end
        `HPDR_ADDR_LO_HI: begin
          s_nxt.rdata = s_r.lo_det[15:8];
        end
        default: begin
          s_nxt.rdata = `HPDR_RST_BYTE;
        end
      endcase
    end

    // summary interrupt from flags both set and enabled, registered
    s_nxt.irq = |({(s_nxt.q_cnt != 3'h0), s_nxt.sts} & s_nxt.ien);
  end

  // ========================================================================
  // state register; clock enable low freezes everything
  // reset is synchronous, so the clock must run while it is held
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      s_r <= '0;
    end else if (clk_en_in) begin
      s_r <= s_nxt;
    end
  end

  // ========================================================================
  // outputs
  assign rdata_out = s_r.rdata;
  assign hot_plug_summary_irq_out = s_r.irq;
  // push-pull only: enable is high whenever the pin drives, no open-drain mode
  // one assignment keeps the pin struct a variable with a single driver
  assign hot_plug_pin_out = '{
    out: s_r.en & s_r.dir & s_r.out_val,
    oe: s_r.en & s_r.dir
  };

endmodule

`default_nettype wire

// >>> tb/hpdr_receiver_props.sv
// checker for the hot-plug receiver, seeing only its ports.
// assumes one clock and the register map of hpdr_cfg.svh.
`timescale 1ns/1ps
`include "hpdr_cfg.svh"
`default_nettype none
module hpdr_receiver_props (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire hpdr_pkg::hpdr_bus_type bus_in,
  input wire logic [7:0] rdata_out,
  input wire logic hot_plug_pin_in,
  input wire hpdr_pkg::hpdr_pin_type hot_plug_pin_out,
  input wire logic hot_plug_summary_irq_out
);
  // ==========================================================================
  // shadows of control and enable, taken as the design takes writes
  logic [7:0] ctl_r;
  logic [3:0] ien_r;
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      ctl_r <= 8'h00;
      ien_r <= 4'h0;
    end else if (clk_en_in && bus_in.wr) begin
      if (bus_in.addr == `HPDR_ADDR_CTL) ctl_r <= bus_in.wdata;
      if (bus_in.addr == `HPDR_ADDR_IEN) ien_r <= bus_in.wdata[3:0];
    end
  end
  wire en_w = ctl_r[`HPDR_CTL_EN];
  wire dir_w = ctl_r[`HPDR_CTL_DIR];
  wire outv_w = ctl_r[`HPDR_CTL_OUTV];
  wire rx_w = en_w && !dir_w;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  // ==========================================================================
  // read requests as taken by the port
  sequence ctl_read;
    clk_en_in && bus_in.rd && bus_in.addr == `HPDR_ADDR_CTL;
  endsequence
  sequence sts_read;
    clk_en_in && bus_in.rd && bus_in.addr == `HPDR_ADDR_STS;
  endsequence
  sequence q_read;
    clk_en_in && bus_in.rd && bus_in.addr == `HPDR_ADDR_QUEUE;
  endsequence
  drive_enable_a: assert property (hot_plug_pin_out.oe == (en_w && dir_w))
    else $error("pin enable disagrees with control");
  drive_value_a: assert property (hot_plug_pin_out.out == (en_w && dir_w && outv_w))
    else $error("pin value disagrees with control");
  state_off_a: assert property (ctl_read ##0 !en_w |=> !rdata_out[7])
    else $error("pin state set while disabled");
  out_read_a: assert property (ctl_read ##0 (en_w && dir_w)
    |=> rdata_out[7:3] == {$past(outv_w), 3'h0, $past(outv_w)})
    else $error("output value read back wrong");
  quiet_off_a: assert property ((!en_w) [*3] |-> !hot_plug_summary_irq_out)
    else $error("interrupt while disabled");
  irq_masked_a: assert property (hot_plug_summary_irq_out |-> ien_r != 4'h0)
    else $error("interrupt with all enables clear");
  sts_off_a: assert property ((!en_w) [*2] ##0 sts_read |=> rdata_out == 8'h00)
    else $error("status not zero while disabled");
  queue_idle_a: assert property ((!rx_w) [*2] ##0 q_read |=> rdata_out == 8'h00)
    else $error("queue holds entries while not receiving");
endmodule
bind hpdr_receiver hpdr_receiver_props props_u (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
  .clk_en_in(clk_en_in), .bus_in(bus_in), .rdata_out(rdata_out), .hot_plug_pin_in(hot_plug_pin_in),
  .hot_plug_pin_out(hot_plug_pin_out), .hot_plug_summary_irq_out(hot_plug_summary_irq_out));
`default_nettype wire

// >>> tb/hpdr_display_model.sv
// display-side driver of the hot-plug line.
// assumes the bench commands plug level and low pulses in clock cycles.
`timescale 1ns/1ps
`default_nettype none
module hpdr_display_model (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic plugged_in,
  input wire logic pulse_go_in,
  input wire logic [15:0] pulse_cyc_in,
  output logic line_out
);
  // ==========================================================================
  // low pulse timer; out-of-bound widths only when the bench asks for them
  logic [15:0] left_r;
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      left_r <= 16'h0000;
    end else if (pulse_go_in) begin
      left_r <= pulse_cyc_in;
    end else if (left_r != 16'h0000) begin
      left_r <= left_r - 16'h0001;
    end
  end
  // a pulse only pulls down a plugged line
  assign line_out = plugged_in && (left_r == 16'h0000);
endmodule
`default_nettype wire

// >>> tb/hpdr_receiver_tb.sv
// bench for the hot-plug receiver: register port, display model, checks.
// assumes 10 us ticks of 250 cycles and the map of hpdr_cfg.svh.
`timescale 1ns/1ps
`include "hpdr_cfg.svh"
`default_nettype none
module hpdr_receiver_tb;
  logic clock_in;
  logic sys_rst_in;
  logic clk_en;
  hpdr_pkg::hpdr_bus_type bus_in;
  logic [7:0] rdata_out;
  hpdr_pkg::hpdr_pin_type pin_out;
  logic irq_out;
  logic plugged;
  logic pulse_go;
  logic [15:0] pulse_cyc;
  logic model_line;
  wire hpd_line;
  int num_errors;
  int samples_checked;
  // the receiver owns the wire while it drives
  assign hpd_line = pin_out.oe ? pin_out.out : model_line;
  hpdr_receiver dut_u (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en), .bus_in(bus_in),
    .rdata_out(rdata_out), .hot_plug_pin_in(hpd_line), .hot_plug_pin_out(pin_out),
    .hot_plug_summary_irq_out(irq_out));
  hpdr_display_model disp_u (.clock_in(clock_in), .rst_in(sys_rst_in), .plugged_in(plugged),
    .pulse_go_in(pulse_go), .pulse_cyc_in(pulse_cyc), .line_out(model_line));
  // ==========================================================================
  // shared tasks; one idle cycle after each strobe
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // level outputs are compared mid-cycle, away from the edge that launches them
  task automatic out_check(input bit pick_pin, input logic [7:0] exp);
    @(negedge clock_in);
    check(pick_pin ? {6'h00, pin_out} : {7'h00, irq_out}, exp);
    @(posedge clock_in);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock_in);
    bus_in <= '0;
    @(posedge clock_in);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    bus_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock_in);
    bus_in <= '0;
    @(negedge clock_in);
    check(rdata_out, exp);
    @(posedge clock_in);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  task automatic pulse(input logic [15:0] n, input int wait_n);
    pulse_go <= 1'b1;
    pulse_cyc <= n;
    @(posedge clock_in);
    pulse_go <= 1'b0;
    idle(wait_n);
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_reset();
    rd(`HPDR_ADDR_CTL, 8'h00);
    rd(`HPDR_ADDR_STS, 8'h00);
    rd(`HPDR_ADDR_QUEUE, 8'h00);
    rd(12'hc0a, 8'h00);
  endtask
  task automatic t_connect();
    wr(`HPDR_ADDR_MIN, 8'h01);
    wr(`HPDR_ADDR_MAX, 8'h03);
    wr(`HPDR_ADDR_HI_LO, 8'h02);
    wr(`HPDR_ADDR_LO_LO, 8'h06);
    wr(`HPDR_ADDR_IEN, 8'h0f);
    rd(`HPDR_ADDR_MIN, 8'h01);
    rd(`HPDR_ADDR_MAX, 8'h03);
    rd(`HPDR_ADDR_HI_LO, 8'h02);
    rd(`HPDR_ADDR_LO_LO, 8'h06);
    rd(`HPDR_ADDR_IEN, 8'h0f);
    wr(`HPDR_ADDR_CTL, 8'h01);
    plugged <= 1'b1;
    idle(100);
    rd(`HPDR_ADDR_CTL, 8'h01);
    idle(500);
    rd(`HPDR_ADDR_STS, 8'h0a);
    rd(`HPDR_ADDR_CTL, 8'h81);
    rd(`HPDR_ADDR_QUEUE, 8'h01);
    out_check(1'b0, 8'h01);
  endtask
  task automatic t_pulse();
    pulse(16'd500, 300);
    rd(`HPDR_ADDR_CTL, 8'h81);
    idle(300);
    rd(`HPDR_ADDR_STS, 8'h0b);
    rd(`HPDR_ADDR_QUEUE, 8'h0d);
    wr(`HPDR_ADDR_STS, 8'h07);
    pulse(16'd50, 100);
    pulse(16'd1100, 1200);
    rd(`HPDR_ADDR_QUEUE, 8'h0d);
    rd(`HPDR_ADDR_CTL, 8'h81);
    rd(`HPDR_ADDR_STS, 8'h08);
  endtask
  task automatic t_unplug();
    plugged <= 1'b0;
    idle(1300);
    rd(`HPDR_ADDR_CTL, 8'h81);
    idle(300);
    rd(`HPDR_ADDR_STS, 8'h0c);
    rd(`HPDR_ADDR_CTL, 8'h01);
    plugged <= 1'b1;
    idle(600);
    wr(`HPDR_ADDR_STS, 8'h07);
    rd(`HPDR_ADDR_STS, 8'h08);
    pulse(16'd500, 600);
    rd(`HPDR_ADDR_QUEUE, 8'h6d);
    rd(`HPDR_ADDR_STS, 8'h09);
    out_check(1'b0, 8'h01);
    wr(`HPDR_ADDR_IEN, 8'h00);
    out_check(1'b0, 8'h00);
    wr(`HPDR_ADDR_QUEUE, 8'h00);
    rd(`HPDR_ADDR_QUEUE, 8'h00);
  endtask
  task automatic t_output();
    wr(`HPDR_ADDR_CTL, 8'h00);
    rd(`HPDR_ADDR_STS, 8'h00);
    wr(`HPDR_ADDR_CTL, 8'h0b);
    out_check(1'b1, 8'h03);
    rd(`HPDR_ADDR_CTL, 8'h8b);
    // a frozen clock enable must swallow this write
    clk_en <= 1'b0;
    wr(`HPDR_ADDR_CTL, 8'h00);
    clk_en <= 1'b1;
    rd(`HPDR_ADDR_CTL, 8'h8b);
    pulse(16'd500, 600);
    rd(`HPDR_ADDR_STS, 8'h00);
    wr(`HPDR_ADDR_HI_HI, 8'h5a);
    rd(`HPDR_ADDR_HI_HI, 8'h5a);
    wr(`HPDR_ADDR_LO_HI, 8'ha5);
    rd(`HPDR_ADDR_LO_HI, 8'ha5);
  endtask
  task automatic wrap_up();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // clock, watchdog and main sequence
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  initial begin
    idle(20000);
    num_errors++;
    wrap_up();
  end
  initial begin
    sys_rst_in = 1'b1;
    bus_in = '0;
    plugged = 1'b0;
    pulse_go = 1'b0;
    pulse_cyc = 16'h0000;
    clk_en = 1'b1;
    num_errors = 0;
    samples_checked = 0;
    idle(4);
    sys_rst_in <= 1'b0;
    @(posedge clock_in);
    t_reset();
    t_connect();
    t_pulse();
    t_unplug();
    t_output();
    wrap_up();
  end
endmodule
`default_nettype wire
